// ### rtl/pfac_flash_array.sv
// Storage of the user program area and the calibration words.
// Assumes erase and program requests never coincide with a read.
`timescale 1ns/100ps
module pfac_flash_array (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic rd_en_i,
  input wire logic cal_sel_i,
  input wire logic [pfac_pkg::MEM_AW-1:0] addr_i,
  input wire logic erase_i,
  input wire logic prog_i,
  input wire logic [pfac_pkg::ROW_WORDS*pfac_pkg::WORD_W-1:0] row_i,
  output logic [pfac_pkg::WORD_W-1:0] rdata_o
);
  import pfac_pkg::*;
  logic [WORD_W-1:0] mem [MEM_WORDS];
  logic [WORD_W-1:0] cal [CAL_WORDS];
  logic [WORD_W-1:0] rdata_reg;
  logic [MEM_AW-3:0] row;
  assign row = addr_i[MEM_AW-1:2];

  // The whole row is written at once; erase leaves every cell at all ones.
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < ROW_WORDS; i++) begin
      if (erase_i) begin
        mem[{row, 2'(i)}] <= ERASED_WORD;
      end else if (prog_i) begin
        mem[{row, 2'(i)}] <= row_i[i*WORD_W +: WORD_W];
      end
    end
  end

  // Calibration words are never writable from this path.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < CAL_WORDS; i++) begin
        cal[i] <= ERASED_WORD;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= '0;
    end else if (rd_en_i) begin
      rdata_reg <= cal_sel_i ? cal[addr_i[CAL_AW-1:0]] : mem[addr_i];
    end
  end

  assign rdata_o = rdata_reg;
endmodule

// ### rtl/pfac_pkg.sv
// Shared constants and types of the program flash access control block.
// Assumes one 250 MHz clock and a plain byte-wide register port.
package pfac_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ERASE_TIME_NS = 2_000_000;
  localparam int PROG_TIME_NS = 2_000_000;
  localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 20;
  localparam int RA_W = 3;
  localparam int WORD_W = 14;
  localparam int FADDR_W = 13;
  localparam int MEM_AW = 12;
  localparam int MEM_WORDS = 4096;
  localparam int ROW_WORDS = 4;
  localparam int CAL_AW = 3;
  localparam int CAL_WORDS = 8;
  localparam logic [RA_W-1:0] OFS_DATA_LOW = 3'h0;
  localparam logic [RA_W-1:0] OFS_DATA_HIGH = 3'h1;
  localparam logic [RA_W-1:0] OFS_ADDR_LOW = 3'h2;
  localparam logic [RA_W-1:0] OFS_ADDR_HIGH = 3'h3;
  localparam logic [RA_W-1:0] OFS_CONTROL = 3'h4;
  localparam logic [RA_W-1:0] OFS_UNLOCK = 3'h5;
  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_ALLOW = 2;
  localparam int CTL_CAL = 6;
  localparam int CTL_TOP = 7;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3FFF;
  localparam logic [1:0] LAST_IN_ROW = 2'h3;
  localparam logic [1:0] WP_NONE = 2'h3;
  localparam logic [1:0] WP_LOW = 2'h2;
  localparam logic [1:0] WP_HALF = 2'h1;
  localparam logic [MEM_AW-1:0] WP_LOW_END = 12'h01FF;
  localparam logic [MEM_AW-1:0] WP_HALF_END = 12'h07FF;
  typedef struct packed {
    logic [RA_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfac_req_t;
  typedef struct packed {
    logic busy;
    logic fetch_hold;
    logic prog_grant;
  } pfac_stat_t;
endpackage

// ### rtl/pfac_top.sv
// Register-driven read and row write access to the on-chip program flash.
// Assumes the core drives the register port as single-cycle strobes.
// How it works
// - Data low and high registers form one 14-bit flash word.
// - Address low and high registers form one 13-bit word address.
// - Program flash holds 4k words, addresses 0000h to 0FFFh.
// - Reads move one word; writes commit four words per row.
// - A row write erases the row first, then programs it.
// - An internal timer sets how long erase and program last.
// - Code protection does not block core reads or writes.
// - Write protect setting blocks writes to chosen blocks; reads stay open.
// - Code protection denies the external programmer all access.
// - Software can only set read and write request bits, never clear.
// - Hardware clears the request bit when its operation completes.
// - Writes start only with write allow set; it resets cleared.
// - Calibration select steers reads to the calibration words.
// - A write requested with calibration select set changes no flash cell; its word still enters the row latch.
// - The unlock port stores nothing and reads as zero.
// - Data bits 7-0 sit in the data low register.
// - Address low register bits 7-0 are address bits 7-0.
// - Data high holds bits 13-8 in 5-0; bits 7-6 read zero.
// - Address high implements bits 3-0 only; 7-4 read zero.
// - A read skips one cycle, fetches next, data valid after.
// - Data registers keep the last read until read or written.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module pfac_top #(
  parameter int ERASE_CYCLES = pfac_pkg::ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = pfac_pkg::PROG_CYCLES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire pfac_pkg::pfac_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic code_protect_i,
  input wire logic [1:0] block_write_protect_i,
  input wire logic prog_access_req_i,
  output pfac_pkg::pfac_stat_t status_o
);
  import pfac_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_RD_SKIP = 7'b000_0010,
    S_RD_FETCH = 7'b000_0100,
    S_RD_LOAD = 7'b000_1000,
    S_ERASE = 7'b001_0000,
    S_PROG = 7'b010_0000,
    S_WR_END = 7'b100_0000
  } pfac_state_t;

  typedef enum logic [2:0] {
    U_LOCKED = 3'b001,
    U_KEY1 = 3'b010,
    U_ARMED = 3'b100
  } pfac_unlock_t;

  pfac_state_t state_reg, state_next;
  pfac_unlock_t unlock_reg;
  logic [7:0] data_low_reg;
  logic [5:0] data_high_reg;
  logic [7:0] addr_low_reg;
  logic [3:0] addr_high_reg;
  logic rd_reg, wr_reg, write_allow_reg, cal_sel_reg;
  logic [7:0] rdata_reg;
  logic [WORD_W-1:0] latch_reg [ROW_WORDS];
  logic [ROW_WORDS*WORD_W-1:0] row_data;
  logic [FADDR_W-1:0] word_addr;
  logic [MEM_AW-1:0] mem_addr;
  logic [WORD_W-1:0] flash_word;
  logic [WORD_W-1:0] mem_rdata;
  logic wr_ctl, wr_unlock, rd_set, wr_set, wr_accept;
  logic protected_addr, last_word;
  logic erase_go_reg, prog_go_reg, timer_start_reg;
  logic [TMR_W-1:0] timer_cycles_reg;
  logic timer_done;
  logic rd_done, wr_done;

  localparam logic [TMR_W-1:0] ERASE_CNT = TMR_W'(ERASE_CYCLES);
  localparam logic [TMR_W-1:0] PROG_CNT = TMR_W'(PROG_CYCLES);

  assign word_addr = {1'b0, addr_high_reg, addr_low_reg};
  assign mem_addr = word_addr[MEM_AW-1:0];
  assign flash_word = {data_high_reg, data_low_reg};
  assign last_word = (mem_addr[1:0] == LAST_IN_ROW);

  assign wr_ctl = reg_req_i.wr && (reg_req_i.addr == OFS_CONTROL);
  assign wr_unlock = reg_req_i.wr && (reg_req_i.addr == OFS_UNLOCK);
  assign rd_set = wr_ctl && reg_req_i.wdata[CTL_RD];
  assign wr_set = wr_ctl && reg_req_i.wdata[CTL_WR];
  // Write allow must already be set; setting it in the same write does not count.
  assign wr_accept = wr_set && !wr_reg && !rd_reg && write_allow_reg
                     && (unlock_reg == U_ARMED);

  // Code protection is not consulted here, so the core keeps full access.
  always_comb begin
    unique case (block_write_protect_i)
      WP_NONE: protected_addr = 1'b0;
      WP_LOW: protected_addr = (mem_addr <= WP_LOW_END);
      WP_HALF: protected_addr = (mem_addr <= WP_HALF_END);
      default: protected_addr = 1'b1;
    endcase
  end

  assign rd_done = (state_reg == S_RD_LOAD);
  assign wr_done = (state_reg == S_WR_END);

  // A read request arriving as the old read completes stays set and runs next; one arriving during a write is dropped.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rd_reg <= 1'b0;
    end else if (rd_set && !wr_reg) begin
      rd_reg <= 1'b1;
    end else if (rd_done) begin
      rd_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wr_reg <= 1'b0;
    end else if (wr_accept) begin
      wr_reg <= 1'b1;
    end else if (wr_done) begin
      wr_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      write_allow_reg <= 1'b0;
      cal_sel_reg <= 1'b0;
    end else if (wr_ctl) begin
      write_allow_reg <= reg_req_i.wdata[CTL_ALLOW];
      cal_sel_reg <= reg_req_i.wdata[CTL_CAL];
    end
  end

  // Any control write spends the unlock, so a stray sequence cannot linger.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      unlock_reg <= U_LOCKED;
    end else if (wr_ctl) begin
      unlock_reg <= U_LOCKED;
    end else if (wr_unlock) begin
      unique case (unlock_reg)
        U_LOCKED: unlock_reg <= (reg_req_i.wdata == UNLOCK_KEY1) ? U_KEY1 : U_LOCKED;
        U_KEY1: unlock_reg <= (reg_req_i.wdata == UNLOCK_KEY2) ? U_ARMED : U_LOCKED;
        U_ARMED: unlock_reg <= U_LOCKED;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      addr_low_reg <= BYTE_ZERO;
      addr_high_reg <= '0;
    end else if (reg_req_i.wr && !wr_reg) begin
      if (reg_req_i.addr == OFS_ADDR_LOW) begin
        addr_low_reg <= reg_req_i.wdata;
      end
      if (reg_req_i.addr == OFS_ADDR_HIGH) begin
        addr_high_reg <= reg_req_i.wdata[3:0];
      end
    end
  end

  // Software writes and read results share the data registers.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      data_low_reg <= BYTE_ZERO;
      data_high_reg <= '0;
    end else if (rd_done) begin
      data_low_reg <= mem_rdata[7:0];
      data_high_reg <= mem_rdata[WORD_W-1:8];
    end else if (reg_req_i.wr && !wr_reg) begin
      if (reg_req_i.addr == OFS_DATA_LOW) begin
        data_low_reg <= reg_req_i.wdata;
      end
      if (reg_req_i.addr == OFS_DATA_HIGH) begin
        data_high_reg <= reg_req_i.wdata[5:0];
      end
    end
  end

  // Each accepted write stores its word in the row latch at its column.
  generate
    for (genvar g = 0; g < ROW_WORDS; g++) begin : g_latch
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          latch_reg[g] <= ERASED_WORD;
        end else if (wr_accept && (mem_addr[1:0] == 2'(g))) begin
          latch_reg[g] <= flash_word;
        end
      end
      assign row_data[g*WORD_W +: WORD_W] = latch_reg[g];
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (wr_reg) begin
          if (cal_sel_reg || protected_addr || !last_word) begin
            state_next = S_WR_END;
          end else begin
            state_next = S_ERASE;
          end
        end else if (rd_reg || rd_set) begin
          // Leaving on the request itself keeps the fetch in the second cycle after it.
          state_next = S_RD_SKIP;
        end
      end
      S_RD_SKIP: state_next = S_RD_FETCH;
      S_RD_FETCH: state_next = S_RD_LOAD;
      S_RD_LOAD: state_next = S_IDLE;
      S_ERASE: state_next = timer_done ? S_PROG : S_ERASE;
      S_PROG: state_next = timer_done ? S_WR_END : S_PROG;
      S_WR_END: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Erase and program pulses land on the first cycle of their timed phase.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      erase_go_reg <= 1'b0;
      prog_go_reg <= 1'b0;
      timer_start_reg <= 1'b0;
      timer_cycles_reg <= '0;
    end else begin
      erase_go_reg <= (state_reg == S_IDLE) && (state_next == S_ERASE);
      prog_go_reg <= (state_reg == S_ERASE) && (state_next == S_PROG);
      timer_start_reg <= (state_next != state_reg)
                         && ((state_next == S_ERASE) || (state_next == S_PROG));
      timer_cycles_reg <= (state_next == S_ERASE) ? ERASE_CNT : PROG_CNT;
    end
  end

  pfac_write_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .start_i(timer_start_reg),
    .cycles_i(timer_cycles_reg),
    .done_o(timer_done)
  );

  pfac_flash_array u_array (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .rd_en_i(state_reg == S_RD_FETCH),
    .cal_sel_i(cal_sel_reg),
    .addr_i(mem_addr),
    .erase_i(erase_go_reg),
    .prog_i(prog_go_reg),
    .row_i(row_data),
    .rdata_o(mem_rdata)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= BYTE_ZERO;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        OFS_DATA_LOW: rdata_reg <= data_low_reg;
        OFS_DATA_HIGH: rdata_reg <= {2'b00, data_high_reg};
        OFS_ADDR_LOW: rdata_reg <= addr_low_reg;
        OFS_ADDR_HIGH: rdata_reg <= {4'h0, addr_high_reg};
        OFS_CONTROL: begin
          rdata_reg <= BYTE_ZERO;
          rdata_reg[CTL_TOP] <= 1'b1;
          rdata_reg[CTL_CAL] <= cal_sel_reg;
          rdata_reg[CTL_ALLOW] <= write_allow_reg;
          rdata_reg[CTL_WR] <= wr_reg;
          rdata_reg[CTL_RD] <= rd_reg;
        end
        OFS_UNLOCK: rdata_reg <= BYTE_ZERO;
        default: rdata_reg <= BYTE_ZERO;
      endcase
    end else begin
      rdata_reg <= BYTE_ZERO;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign status_o.busy = rd_reg || wr_reg;
  assign status_o.fetch_hold = (state_reg == S_RD_FETCH);
  assign status_o.prog_grant = prog_access_req_i && !code_protect_i;
endmodule

// ### rtl/pfac_write_timer.sv
// Down-counter that times one erase or program phase.
// Assumes start_i is a one-cycle pulse and is not raised while busy.
`timescale 1ns/100ps
module pfac_write_timer (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [pfac_pkg::TMR_W-1:0] cycles_i,
  output logic done_o
);
  import pfac_pkg::*;
  logic [TMR_W-1:0] cnt_reg;
  logic done_reg;
  localparam logic [TMR_W-1:0] ONE = 20'h0_0001;
  localparam logic [TMR_W-1:0] ZERO = 20'h0_0000;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= ZERO;
    end else if (start_i) begin
      cnt_reg <= cycles_i;
    end else if (cnt_reg != ZERO) begin
      cnt_reg <= cnt_reg - ONE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= !start_i && (cnt_reg == ONE);
    end
  end

  assign done_o = done_reg;
endmodule

// ### test/pfac_core_model.sv
// Stand-in for the processor core that drives the register port.
// Assumes one caller at a time; each task starts on the next rising edge.
`timescale 1ns/100ps
module pfac_core_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output pfac_pkg::pfac_req_t req_o
);
  import pfac_pkg::*;
  initial req_o = '0;
  // Idle cycles show inverted values so nothing leans on a stale bus.
  task automatic reg_write(input logic [RA_W-1:0] ofs, input logic [7:0] val);
    @(posedge ref_clk_i);
    req_o <= '{addr: ofs, wdata: val, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req_o <= '{addr: ~ofs, wdata: ~val, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic reg_read(input logic [RA_W-1:0] ofs, output logic [7:0] val);
    @(posedge ref_clk_i);
    req_o <= '{addr: ofs, wdata: BYTE_ZERO, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req_o <= '{addr: ~ofs, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(negedge ref_clk_i);
    val = rdata_i;
  endtask
  task automatic load_addr(input logic [FADDR_W-1:0] a);
    reg_write(OFS_ADDR_HIGH, {3'h0, a[12:8]});
    reg_write(OFS_ADDR_LOW, a[7:0]);
  endtask
  task automatic unlock();
    reg_write(OFS_UNLOCK, UNLOCK_KEY1);
    reg_write(OFS_UNLOCK, UNLOCK_KEY2);
  endtask
endmodule

// ### test/pfac_top_props.sv
// Port-level checks on the flash access block, attached by bind.
// Assumes the core never asks for a read and a write in one request.
`timescale 1ns/100ps
module pfac_top_props #(
  parameter int ERASE_CYCLES = 5,
  parameter int PROG_CYCLES = 5
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire pfac_pkg::pfac_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic code_protect_i,
  input wire logic [1:0] block_write_protect_i,
  input wire logic prog_access_req_i,
  input wire pfac_pkg::pfac_stat_t status_o
);
  import pfac_pkg::*;
  int busy_run;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // A request bit that is never cleared would leave the core stalled for good.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || !status_o.busy) begin
      busy_run <= 0;
    end else begin
      busy_run <= busy_run + 1;
    end
  end
  a_grant_follows_protect:
    assert property (status_o.prog_grant == (prog_access_req_i && !code_protect_i))
    else $error("programmer grant wrong");
  a_rdata_idle_zero:
    assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == BYTE_ZERO)
    else $error("read data outside its cycle");
  a_read_fetch_slot:
    assert property (reg_req_i.wr && reg_req_i.addr == OFS_CONTROL && reg_req_i.wdata[CTL_RD]
      && !reg_req_i.wdata[CTL_WR] && !status_o.busy |-> ##1 (status_o.busy
      && !status_o.fetch_hold) ##1 status_o.fetch_hold ##1 !status_o.fetch_hold ##1 !status_o.busy)
    else $error("read timing wrong");
  a_fetch_while_busy:
    assert property (status_o.fetch_hold |-> status_o.busy && $past(status_o.busy))
    else $error("fetch without request");
  a_unlock_reads_zero:
    assert property (reg_req_i.rd && reg_req_i.addr == OFS_UNLOCK |=> reg_rdata_o == BYTE_ZERO)
    else $error("unlock port not zero");
  a_data_high_top:
    assert property (reg_req_i.rd && reg_req_i.addr == OFS_DATA_HIGH |=> reg_rdata_o[7:6] == 2'h0)
    else $error("data high top bits set");
  a_addr_high_top:
    assert property (reg_req_i.rd && reg_req_i.addr == OFS_ADDR_HIGH |=> reg_rdata_o[7:4] == 4'h0)
    else $error("address high top bits set");
  a_busy_bounded:
    assert property (busy_run <= ERASE_CYCLES + PROG_CYCLES + 16)
    else $error("request bit held too long");
endmodule
bind pfac_top pfac_top_props #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)
) u_props (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o),
  .code_protect_i(code_protect_i),
  .block_write_protect_i(block_write_protect_i),
  .prog_access_req_i(prog_access_req_i),
  .status_o(status_o)
);

// ### test/tb_program_flash_access_control.sv
// Self-checking bench for the flash access block.
// Assumes short erase and program counts so whole rows finish quickly.
`timescale 1ns/100ps
module tb_program_flash_access_control;
  import pfac_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic code_protect_i = 1'b1;
  logic [1:0] block_write_protect_i = WP_LOW;
  logic prog_access_req_i = 1'b1;
  pfac_req_t req;
  logic [7:0] rdata;
  pfac_stat_t status;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] b;
  logic [WORD_W-1:0] w;
  always #2 ref_clk_i = ~ref_clk_i;
  pfac_top #(.ERASE_CYCLES(5), .PROG_CYCLES(5)) dut (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .code_protect_i(code_protect_i),
    .block_write_protect_i(block_write_protect_i),
    .prog_access_req_i(prog_access_req_i),
    .status_o(status)
  );
  pfac_core_model core (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkw(input string what, input logic [WORD_W-1:0] exp,
      input logic [WORD_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_idle();
    int cyc;
    cyc = 0;
    @(negedge ref_clk_i);
    while (status.busy !== 1'b0 && cyc < 1000) begin
      @(negedge ref_clk_i);
      cyc++;
    end
    chk8("idle", 8'h00, {7'h00, status.busy});
  endtask
  // The last column commits the row, so its request is read back while still running, then the task waits for idle.
  task automatic write_row(input logic [FADDR_W-1:0] base, input logic [WORD_W-1:0] seed,
      input logic [7:0] ctl, output logic [7:0] st);
    logic [WORD_W-1:0] v;
    for (int i = 0; i < ROW_WORDS; i++) begin
      v = seed + WORD_W'(i);
      core.load_addr(base + FADDR_W'(i));
      core.reg_write(OFS_DATA_LOW, v[7:0]);
      core.reg_write(OFS_DATA_HIGH, {2'h0, v[13:8]});
      core.reg_write(OFS_CONTROL, ctl & 8'hFD);
      core.unlock();
      core.reg_write(OFS_CONTROL, ctl);
      if (i < ROW_WORDS - 1) begin
        wait_idle();
      end
    end
    core.reg_write(OFS_CONTROL, ctl & 8'hFD);
    core.reg_read(OFS_CONTROL, st);
    wait_idle();
  endtask
  task automatic flash_read(input logic [FADDR_W-1:0] a, input logic [7:0] cal,
      output logic [WORD_W-1:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    core.load_addr(a);
    core.reg_write(OFS_CONTROL, 8'h05 | cal);
    wait_idle();
    core.reg_read(OFS_DATA_LOW, lo);
    core.reg_read(OFS_DATA_HIGH, hi);
    v = {hi[5:0], lo};
  endtask
  task automatic check_row(input logic [FADDR_W-1:0] base, input logic [WORD_W-1:0] seed);
    logic [WORD_W-1:0] v;
    for (int i = 0; i < ROW_WORDS; i++) begin
      flash_read(base + FADDR_W'(i), 8'h00, v);
      chkw("row word", seed + WORD_W'(i), v);
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk8("grant", 8'h00, {7'h00, status.prog_grant});
    for (int i = 0; i < 8; i++) begin
      core.reg_read(RA_W'(i), b);
      chk8("reset value", (i == 4) ? 8'h80 : 8'h00, b);
    end
    core.reg_write(OFS_DATA_HIGH, 8'hFF);
    core.reg_read(OFS_DATA_HIGH, b);
    chk8("data high", 8'h3F, b);
    core.reg_write(OFS_ADDR_HIGH, 8'hFF);
    core.reg_read(OFS_ADDR_HIGH, b);
    chk8("addr high", 8'h0F, b);
    core.unlock();
    core.reg_write(OFS_CONTROL, 8'h06);
    core.reg_read(OFS_CONTROL, b);
    chk8("no allow", 8'h84, b);
    core.reg_write(OFS_CONTROL, 8'h06);
    core.reg_read(OFS_CONTROL, b);
    chk8("no unlock", 8'h84, b);
    write_row(13'h0204, 14'h2A50, 8'h06, b);
    chk8("clear in write", 8'h86, b);
    check_row(13'h0204, 14'h2A50);
    @(posedge ref_clk_i);
    block_write_protect_i <= WP_HALF;
    write_row(13'h0204, 14'h1111, 8'h06, b);
    chk8("protected", 8'h84, b);
    @(posedge ref_clk_i);
    block_write_protect_i <= WP_NONE;
    write_row(13'h0204, 14'h0777, 8'h46, b);
    chk8("cal write", 8'hC4, b);
    check_row(13'h0204, 14'h2A50);
    flash_read(13'h0002, 8'h40, w);
    chkw("cal word", ERASED_WORD, w);
    write_row(13'h0FFC, 14'h3ABC, 8'h06, b);
    chk8("top row write", 8'h86, b);
    check_row(13'h0FFC, 14'h3ABC);
    @(posedge ref_clk_i);
    block_write_protect_i <= 2'h0;
    write_row(13'h0FFC, 14'h0123, 8'h06, b);
    chk8("all protected", 8'h84, b);
    check_row(13'h0FFC, 14'h3ABC);
    core.reg_read(OFS_ADDR_LOW, b);
    chk8("addr low", 8'hFF, b);
    core.reg_write(OFS_ADDR_LOW, 8'h00);
    core.reg_read(OFS_DATA_LOW, b);
    chk8("held data", 8'hBF, b);
    @(posedge ref_clk_i);
    code_protect_i <= 1'b0;
    @(negedge ref_clk_i);
    chk8("grant", 8'h01, {7'h00, status.prog_grant});
    tally_and_finish();
  end
endmodule
